// ==== cdx_params.svh ====
/*
 Constants for the call / clear / decrement execute block.
 Assumes a 14-bit instruction word and an 8-bit data path.
*/
// Notes on behaviour
// RULE_01: A call first pushes program counter plus one onto the stack top.
// RULE_02: A call loads its 11-bit immediate into counter bits 10 to 0.
// RULE_03: A call fills counter bits 12:11 from branch high latch bits 4:3.
// RULE_04: A call takes two cycles and one word and leaves all flags alone.
// RULE_05: Accumulator clear zeroes the accumulator and sets the zero flag.
// RULE_06: Watchdog restart clears count and prescaler and sets both _n flags.
// RULE_07: A file decrement goes to the accumulator if d is 0, else the file.
// RULE_08: A file decrement has d and a 7-bit address, one cycle, sets zero.
// RULE_09: Decrement zero flag shows an all-zero result; zero wraps to ones.
`ifndef CDX_PARAMS_SVH
`define CDX_PARAMS_SVH
`define CDX_CALL_TOP 3'h4
`define CDX_CLEAR_OP 14'h0103
`define CDX_WDT_OP 14'h0064
`define CDX_DEC_TOP 6'h03
`define CDX_PC_RESET 13'h0000
`define CDX_LATCH_HI 4
`define CDX_LATCH_LO 3
`define CDX_DEST_BIT 7
`endif

// ==== cdx_pkg.sv ====
/*
 Types for the call / clear / decrement execute block.
 Assumes nothing beyond the parameter header.
*/
package cdx_pkg;
    typedef enum logic [2:0] {
        OP_NONE,
        OP_CALL,
        OP_CLEAR,
        OP_WDT,
        OP_DEC
    } op_kind_t;
    typedef struct packed {
        op_kind_t kind;
        logic dest_file;
        logic [6:0] file_addr;
        logic [10:0] target;
    } decoded_t;
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } file_write_t;
endpackage

// ==== cdx_decode.sv ====
/*
 Combinational opcode decoder for the four instructions.
 Assumes a stable instruction word on the core clock.
*/
`timescale 1ns/1ps
`include "cdx_params.svh"
module cdx_decode
    import cdx_pkg::*;
(
    input wire logic [13:0] instr_in,
    output decoded_t dec_out
);
    always_comb begin
        dec_out.kind = OP_NONE;
        dec_out.dest_file = instr_in[`CDX_DEST_BIT];
        dec_out.file_addr = instr_in[6:0];
        dec_out.target = instr_in[10:0];
        if (instr_in[13:11] == `CDX_CALL_TOP) begin
            dec_out.kind = OP_CALL;
        end else if (instr_in == `CDX_CLEAR_OP) begin
            dec_out.kind = OP_CLEAR; // [RULE_05]
        end else if (instr_in == `CDX_WDT_OP) begin
            dec_out.kind = OP_WDT; // [RULE_06]
        end else if (instr_in[13:8] == `CDX_DEC_TOP) begin
            dec_out.kind = OP_DEC; // [RULE_08]
        end
    end
endmodule

// ==== cdx_exec.sv ====
/*
 Execute stage for call, accumulator clear, watchdog restart and
 file decrement. Assumes fetch holds instr_in steady while busy_out
 is high, and the register file answers file_rd_data_in in the same
 cycle as file_addr_out.
*/
`timescale 1ns/1ps
`include "cdx_params.svh"
module cdx_exec
    import cdx_pkg::*;
#(
    parameter int PC_W = 13
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic instr_valid_in,
    input wire logic [13:0] instr_in,
    input wire logic [7:0] branch_high_latch_in,
    input wire logic [7:0] file_rd_data_in,
    output logic [6:0] file_addr_out,
    output file_write_t file_wr_out,
    output logic [7:0] accumulator_out,
    output logic zero_flag_out,
    output logic watchdog_expiry_flag_n_out,
    output logic sleep_entered_flag_n_out,
    output logic watchdog_clear_out,
    output logic push_out,
    output logic [12:0] stack_top_out,
    output logic [12:0] program_counter_out,
    output logic busy_out
);
    if (PC_W != 13) begin : g_pc_w_check
        $error("cdx_exec supports a 13-bit program counter only");
    end

    decoded_t dec;
    logic busy;
    logic go;
    logic [7:0] dec_result;

    cdx_decode u_dec (
        .instr_in(instr_in),
        .dec_out(dec)
    );

    // Second call cycle refuses new work, like a fetch flush
    assign go = ce_in && instr_valid_in && !busy;
    assign busy_out = busy;
    assign file_addr_out = dec.file_addr;
    assign dec_result = file_rd_data_in - 8'h01; // [RULE_09]

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            busy <= 1'b0;
        end else if (ce_in) begin
            busy <= go && dec.kind == OP_CALL; // [RULE_04]
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            program_counter_out <= `CDX_PC_RESET;
            stack_top_out <= `CDX_PC_RESET;
            push_out <= 1'b0;
        end else if (ce_in) begin
            push_out <= 1'b0;
            if (go) begin
                if (dec.kind == OP_CALL) begin
                    stack_top_out <=
                        program_counter_out + 13'h0001; // [RULE_01]
                    push_out <= 1'b1; // [RULE_01]
                    program_counter_out <= {
                        branch_high_latch_in[`CDX_LATCH_HI:`CDX_LATCH_LO],
                        dec.target}; // [RULE_02] [RULE_03]
                end else begin
                    program_counter_out <= program_counter_out + 13'h0001;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            accumulator_out <= 8'h00;
            zero_flag_out <= 1'b0;
            file_wr_out <= '0;
        end else if (ce_in) begin
            file_wr_out.we <= 1'b0;
            if (go && dec.kind == OP_CLEAR) begin
                accumulator_out <= 8'h00; // [RULE_05]
                zero_flag_out <= 1'b1; // [RULE_05]
            end else if (go && dec.kind == OP_DEC) begin
                zero_flag_out <= dec_result == 8'h00; // [RULE_08] [RULE_09]
                if (dec.dest_file) begin
                    file_wr_out.we <= 1'b1; // [RULE_07]
                    file_wr_out.addr <= dec.file_addr;
                    file_wr_out.data <= dec_result;
                end else begin
                    accumulator_out <= dec_result; // [RULE_07]
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            watchdog_expiry_flag_n_out <= 1'b1;
            sleep_entered_flag_n_out <= 1'b1;
            watchdog_clear_out <= 1'b0;
        end else if (ce_in) begin
            watchdog_clear_out <= go && dec.kind == OP_WDT; // [RULE_06]
            if (go && dec.kind == OP_WDT) begin
                watchdog_expiry_flag_n_out <= 1'b1; // [RULE_06]
                sleep_entered_flag_n_out <= 1'b1; // [RULE_06]
            end
        end
    end

    sequence s_call_taken;
        ce_in && instr_valid_in && !busy && dec.kind == OP_CALL;
    endsequence
    property p_push_ret;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        s_call_taken |=> push_out &&
            stack_top_out == $past(program_counter_out) + 13'h0001;
    endproperty
    a_push_ret: assert property (p_push_ret) // [RULE_01]
        else $error("call did not push return address");
    property p_call_low;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        s_call_taken |=> program_counter_out[10:0] == $past(instr_in[10:0]);
    endproperty
    a_call_low: assert property (p_call_low) // [RULE_02]
        else $error("call target low bits wrong");
    property p_call_high;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        s_call_taken |=> program_counter_out[12:11] ==
            $past(branch_high_latch_in[4:3]);
    endproperty
    a_call_high: assert property (p_call_high) // [RULE_03]
        else $error("call target high bits wrong");
    property p_call_two;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        s_call_taken |=> busy_out && $stable(zero_flag_out)
            && $stable(accumulator_out);
    endproperty
    a_call_two: assert property (p_call_two) // [RULE_04]
        else $error("call not two cycles or flags changed");
    property p_clear;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (go && dec.kind == OP_CLEAR) |=> accumulator_out == 8'h00
            && zero_flag_out && !busy_out;
    endproperty
    a_clear: assert property (p_clear) // [RULE_05]
        else $error("accumulator clear failed");
    property p_wdt;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (go && dec.kind == OP_WDT) |=> watchdog_clear_out
            && watchdog_expiry_flag_n_out && sleep_entered_flag_n_out;
    endproperty
    a_wdt: assert property (p_wdt) // [RULE_06]
        else $error("watchdog restart failed");
    property p_dec_dest;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (go && dec.kind == OP_DEC) |=> (file_wr_out.we ==
            $past(instr_in[7])) && (file_wr_out.we || accumulator_out
            == $past(file_rd_data_in) - 8'h01);
    endproperty
    a_dec_dest: assert property (p_dec_dest) // [RULE_07]
        else $error("decrement destination wrong");
    property p_dec_zero;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (go && dec.kind == OP_DEC) |=> zero_flag_out ==
            ($past(file_rd_data_in) == 8'h01) && !busy_out;
    endproperty
    a_dec_zero: assert property (p_dec_zero) // [RULE_08] [RULE_09]
        else $error("decrement zero flag wrong");
    sequence s_call_second;
        ce_in && busy_out;
    endsequence
    property p_call_refuse;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        s_call_second |=> !busy_out && !push_out && !watchdog_clear_out
            && !file_wr_out.we && $stable(program_counter_out);
    endproperty
    a_call_refuse: assert property (p_call_refuse) // [RULE_04]
        else $error("word taken in second call cycle");
    property p_call_quiet;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        s_call_taken |=> !watchdog_clear_out && !file_wr_out.we
            && $stable(watchdog_expiry_flag_n_out)
            && $stable(sleep_entered_flag_n_out);
    endproperty
    a_call_quiet: assert property (p_call_quiet) // [RULE_04]
        else $error("call touched flags or other outputs");
    property p_push_pulse;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (push_out && ce_in) |=> !push_out;
    endproperty
    a_push_pulse: assert property (p_push_pulse) // [RULE_01]
        else $error("push pulse longer than one cycle");
    property p_clear_one;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (go && dec.kind == OP_CLEAR) |=> !push_out && !file_wr_out.we
            && program_counter_out == $past(program_counter_out) + 13'h0001;
    endproperty
    a_clear_one: assert property (p_clear_one) // [RULE_05]
        else $error("accumulator clear not a single cycle");
    property p_wdt_quiet;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (go && dec.kind == OP_WDT) |=> $stable(accumulator_out)
            && $stable(zero_flag_out) && !push_out && !file_wr_out.we;
    endproperty
    a_wdt_quiet: assert property (p_wdt_quiet) // [RULE_06]
        else $error("watchdog restart touched the data path");
    property p_dec_write;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (go && dec.kind == OP_DEC && dec.dest_file) |=>
            file_wr_out.addr == $past(instr_in[6:0])
            && file_wr_out.data == $past(file_rd_data_in) - 8'h01
            && $stable(accumulator_out);
    endproperty
    a_dec_write: assert property (p_dec_write) // [RULE_07]
        else $error("decrement write-back wrong");
    property p_dec_one;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (go && dec.kind == OP_DEC) |=> !busy_out && !push_out
            && program_counter_out == $past(program_counter_out) + 13'h0001;
    endproperty
    a_dec_one: assert property (p_dec_one) // [RULE_08]
        else $error("decrement not a single cycle");
    // Clock enable low must hold counter, busy, accumulator, zero flag, push and write port
    property p_freeze;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !ce_in |=> $stable(program_counter_out) && $stable(busy_out)
            && $stable(accumulator_out) && $stable(zero_flag_out)
            && $stable(push_out) && $stable(file_wr_out);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");
endmodule

// ==== tb.sv ====
/*
 Self-checking bench for the call / clear / decrement execute block.
 Assumes the block answers by the falling edge half a cycle after the taking edge.
*/
`timescale 1ns/1ps
module tb;
import cdx_pkg::*;
logic sys_clk_in = 0, nrst_in = 0, ce_in = 1, instr_valid_in = 0;
logic [13:0] instr_in = 14'h0000;
logic [7:0] branch_high_latch_in = 8'h00, file_rd_data_in = 8'h00;
logic [6:0] file_addr_out;
file_write_t file_wr_out;
logic [7:0] accumulator_out, e_acc = 8'h00;
logic zero_flag_out, watchdog_expiry_flag_n_out, sleep_entered_flag_n_out;
logic watchdog_clear_out, push_out, busy_out, e_z = 0, e_busy = 0;
logic [12:0] stack_top_out, program_counter_out;
logic [12:0] e_pc = 13'h0000, e_top = 13'h0000;
int n_errors = 0, num_checks = 0;
cdx_exec #(.PC_W(13)) i_cdx_exec (.sys_clk_in, .nrst_in, .ce_in,
    .instr_valid_in, .instr_in, .branch_high_latch_in, .file_rd_data_in,
    .file_addr_out, .file_wr_out, .accumulator_out, .zero_flag_out,
    .watchdog_expiry_flag_n_out, .sleep_entered_flag_n_out,
    .watchdog_clear_out, .push_out, .stack_top_out,
    .program_counter_out, .busy_out);
initial begin
    forever #20 sys_clk_in = ~sys_clk_in;
end
task automatic test_done;
    if (n_errors == 0 && num_checks > 0) begin
        $display("== PASSED ==");
    end else begin
        $display("== FAILED ==");
    end
    $finish;
endtask
task automatic chk(input string nm, input logic [15:0] e,
                   input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
        n_errors++;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
endtask
function automatic logic [7:0] dec_of(input logic [7:0] v);
    return v - 8'h01;
endfunction
// Drives at a falling edge, checks one cycle later, leaves valid up
task automatic run(input logic [13:0] ins, input logic [7:0] rd,
                   input logic [7:0] lat);
    logic push, wdc, we, busy;
    logic [7:0] res;
    push = 0;
    wdc = 0;
    we = 0;
    busy = 0;
    res = dec_of(rd);
    instr_in = ins;
    file_rd_data_in = rd;
    branch_high_latch_in = lat;
    instr_valid_in = 1'b1;
    #1 chk("addr", ins[6:0], file_addr_out);
    @(negedge sys_clk_in);
    if (!ce_in) begin
        busy = e_busy;
    end else if (e_busy) begin
        busy = 0;
    end else if (ins[13:11] == 3'h4) begin
        e_top = e_pc + 13'h0001;
        e_pc = {lat[4:3], ins[10:0]};
        push = 1;
        busy = 1;
    end else begin
        e_pc = e_pc + 13'h0001;
        if (ins == 14'h0103) begin
            e_acc = 8'h00;
            e_z = 1;
        end else if (ins == 14'h0064) begin
            wdc = 1;
        end else if (ins[13:8] == 6'h03) begin
            e_z = (res == 8'h00);
            we = ins[7];
            if (!ins[7]) e_acc = res;
        end
    end
    e_busy = busy;
    chk("push", push, push_out);
    chk("top", e_top, stack_top_out);
    chk("pc", e_pc, program_counter_out);
    chk("busy", busy, busy_out);
    chk("acc", e_acc, accumulator_out);
    chk("zero", e_z, zero_flag_out);
    chk("wdclr", wdc, watchdog_clear_out);
    chk("exp_n", 1, watchdog_expiry_flag_n_out);
    chk("slp_n", 1, sleep_entered_flag_n_out);
    chk("we", we, file_wr_out.we);
    if (we) begin
        chk("wr_addr", ins[6:0], file_wr_out.addr);
        chk("wr_data", res, file_wr_out.data);
    end
endtask
function automatic logic [13:0] pick(input int s);
    case (s)
        0: return {3'h4, 11'($urandom)};
        1: return 14'h0103;
        2: return 14'h0064;
        default: return {6'h03, 8'($urandom)};
    endcase
endfunction
initial begin
    void'($urandom(32'h4536014d));
    repeat (2) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    nrst_in = 1;
    chk("rst_pc", 0, program_counter_out);
    run(14'h0103, 8'h5a, 8'h00);
    // Call edges of the immediate and latch, each followed by an ignored word
    run({3'h4, 11'h7ff}, 8'h00, 8'he7);
    run(14'h0301, 8'h10, 8'h00);
    run({3'h4, 11'h000}, 8'h00, 8'h18);
    run(14'h0064, 8'h00, 8'h00);
    run(14'h0385, 8'h01, 8'h00);
    run(14'h0322, 8'h00, 8'h00);
    run(14'h0103, 8'h00, 8'h00);
    // A near miss of the clear and decrement codes and an all-ones word only step the counter
    run(14'h0183, 8'h33, 8'h00);
    run(14'h3fff, 8'h00, 8'h00);
    // Frozen clock enable: a held word must not execute
    ce_in = 0;
    run(14'h037f, 8'h44, 8'h00);
    ce_in = 1;
    repeat (60) begin
        run(pick($urandom_range(3)), 8'($urandom), 8'($urandom));
    end
    instr_valid_in = 0;
    test_done();
end
initial begin
    #(40 * 400);
    n_errors++;
    test_done();
end
endmodule
